// [common/dcc_pkg.sv]
// Package with the register map, field layout and types of the comparator control block.
package dcc_pkg;

  // Register byte addresses on the plain register port.
  localparam logic [7:0] DCC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] DCC_OFF_FLAG    = 8'h04;
  localparam logic [7:0] DCC_OFF_ENABLE  = 8'h08;
  localparam logic [7:0] DCC_OFF_STATUS  = 8'h0C;
  localparam logic [7:0] DCC_OFF_MASK    = 8'h10;

  // Field positions of the comparator control register.
  localparam int DCC_CTL_MODE_LSB  = 0;
  localparam int DCC_CTL_SWITCH    = 3;
  localparam int DCC_CTL_INV1      = 4;
  localparam int DCC_CTL_INV2      = 5;
  localparam int DCC_CTL_RES1      = 6;
  localparam int DCC_CTL_RES2      = 7;

  // Field positions of the enable register.
  localparam int DCC_EN_CHANGE     = 0;
  localparam int DCC_EN_PERIPH     = 1;
  localparam int DCC_EN_GLOBAL     = 2;
  localparam int DCC_EN_ROUTE      = 3;

  // Field positions of the flag, status and mask registers.
  localparam int DCC_FLAG_BIT      = 0;
  localparam int DCC_ST_CHANGE     = 0;
  localparam int DCC_ST_SOFT       = 1;

  // Mode field codes with a special meaning.
  localparam logic [2:0] DCC_MODE_RESET = 3'h0;
  localparam logic [2:0] DCC_MODE_VREF  = 3'h6;
  localparam logic [2:0] DCC_MODE_OFF   = 3'h7;

  // Port pins that become analog inputs, by mode.
  localparam logic [7:0] DCC_PINS_ALL_ANALOG = 8'h7E;
  localparam logic [7:0] DCC_PINS_INPUTS     = 8'h78;
  localparam logic [7:0] DCC_PINS_NONE       = 8'h00;

  // Reset values.
  localparam logic [7:0] DCC_RST_BYTE = 8'h00;
  localparam logic [1:0] DCC_RST_PAIR = 2'h0;
  localparam logic [3:0] DCC_RST_EN   = 4'h0;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } dcc_req_t;

  // Analog side controls.
  typedef struct packed {
    logic       power;
    logic [2:0] mode;
    logic       vref_to_plus;
    logic       minus_pair_sel;
  } dcc_analog_t;

  // Complete module state.
  typedef struct packed {
    logic       alive;
    logic [2:0] mode;
    logic       in_switch;
    logic [1:0] inv;
    logic       flag;
    logic [3:0] en;
    logic [1:0] status;
    logic [1:0] mask;
    logic [1:0] captured;
    logic [1:0] res_s1;
    logic [1:0] res_s2;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] rdata;
  } dcc_state_t;

endpackage

// [rtl/dcc_top.sv]
// Control and event logic around a pair of analog comparators.
`timescale 1ns/1ps
`default_nettype none

module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [1:0]  comp_raw_i,
  output logic             comp_power_o,
  output logic      [2:0]  comp_mode_o,
  output logic             vref_to_plus_o,
  output logic             minus_pair_sel_o,
  input  wire logic [1:0]  port_direction_bits_i,
  output logic      [1:0]  result_pin_o,
  output logic      [1:0]  result_pin_oe_o,
  input  wire logic [7:0]  port_pin_level_i,
  output logic      [7:0]  port_read_data_o,
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             change_irq_o,
  output logic             irq_o
);

  // Pins that the current mode hands over to the comparators as analog inputs.
  // Reset mode frees every comparator pin to analog; the off mode releases all.
  function automatic logic [7:0] dcc_analog_pins(input logic [2:0] mode);
    logic [7:0] pins;
    pins = DCC_PINS_INPUTS;
    if (mode == DCC_MODE_RESET) begin
      pins = DCC_PINS_ALL_ANALOG;
    end else if (mode == DCC_MODE_OFF) begin
      pins = DCC_PINS_NONE;
    end
    return pins;
  endfunction

  // Address decode used both by the write and the read paths.
  function automatic logic dcc_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  dcc_req_t    req;
  dcc_analog_t ana;
  dcc_state_t  state_q;
  dcc_state_t  state_d;
  logic [1:0]  reported;
  logic [1:0]  mismatch;
  logic        ctl_access;
  logic        ctl_write;
  logic        flag_write;
  logic        change_set;
  logic        soft_set;
  logic        irq_chain;
  logic [7:0]  ctl_view;

  // Gather the register port into one request.
  always_comb begin
    req.addr  = reg_addr_i;
    req.wdata = reg_wdata_i;
    req.we    = reg_we_i;
    req.re    = reg_re_i;
  end

  // Reported results: the synchronised comparator levels, each optionally
  // inverted. A raw 1 means the plus input is above the minus input.
  always_comb begin
    reported = state_q.res_s2 ^ state_q.inv;
  end

  // Change detection against the values captured at the last control access.
  // A mismatch is a level, so the flag is set again every cycle until software
  // touches the control register and the captured copy catches up.
  always_comb begin
    mismatch   = reported ^ state_q.captured;
    change_set = |mismatch;
    ctl_access = (req.we | req.re) & dcc_hit(req.addr, DCC_OFF_CONTROL);
    ctl_write  = req.we & dcc_hit(req.addr, DCC_OFF_CONTROL);
    flag_write = req.we & dcc_hit(req.addr, DCC_OFF_FLAG);
    soft_set   = flag_write & req.wdata[DCC_FLAG_BIT];
  end

  // Control register as seen by software; the result bits come from the
  // synchronised comparator path and cannot be written.
  always_comb begin
    ctl_view                   = DCC_RST_BYTE;
    ctl_view[DCC_CTL_MODE_LSB +: 3] = state_q.mode;
    ctl_view[DCC_CTL_SWITCH]   = state_q.in_switch;
    ctl_view[DCC_CTL_INV1]     = state_q.inv[0];
    ctl_view[DCC_CTL_INV2]     = state_q.inv[1];
    ctl_view[DCC_CTL_RES1]     = reported[0];
    ctl_view[DCC_CTL_RES2]     = reported[1];
  end

  // Next-state logic for the whole block.
  always_comb begin
    state_d = state_q;

    // The comparators stay unpowered until the first edge after reset release.
    state_d.alive = 1'b1;

    // Synchronisers for the comparator results and the port pins.
    state_d.res_s1 = comp_raw_i;
    state_d.res_s2 = state_q.res_s1;
    state_d.pin_s1 = port_pin_level_i;
    state_d.pin_s2 = state_q.pin_s1;

    // Control register writes; result bit positions are dropped on purpose.
    if (ctl_write) begin
      state_d.mode   = req.wdata[DCC_CTL_MODE_LSB +: 3];
      state_d.in_switch = req.wdata[DCC_CTL_SWITCH];
      state_d.inv[0] = req.wdata[DCC_CTL_INV1];
      state_d.inv[1] = req.wdata[DCC_CTL_INV2];
    end

    // Any control access recaptures the reported results and so ends the
    // mismatch. A change that lands in the same cycle still shows as a mismatch
    // in that cycle, so its flag and change status are still set.
    if (ctl_access) begin
      state_d.captured = reported;
    end

    // Change flag: a write of 0 clears it, a write of 1 sets it. Hardware
    // setting wins over a clear in the same cycle.
    if (flag_write) begin
      state_d.flag = req.wdata[DCC_FLAG_BIT];
    end
    if (change_set) begin
      state_d.flag = 1'b1;
    end

    // Enable register: change, peripheral, global and pin routing enables.
    if (req.we && dcc_hit(req.addr, DCC_OFF_ENABLE)) begin
      state_d.en = req.wdata[3:0];
    end

    // Interrupt mask register.
    if (req.we && dcc_hit(req.addr, DCC_OFF_MASK)) begin
      state_d.mask = req.wdata[1:0];
    end

    // Sticky status: write one to clear, new events win over the clear.
    if (req.we && dcc_hit(req.addr, DCC_OFF_STATUS)) begin
      state_d.status = state_q.status & ~req.wdata[1:0];
    end
    if (change_set) begin
      state_d.status[DCC_ST_CHANGE] = 1'b1;
    end
    if (soft_set) begin
      state_d.status[DCC_ST_SOFT] = 1'b1;
    end

    // Read data stand in the cycle after the read strobe only.
    state_d.rdata = DCC_RST_BYTE;
    if (req.re) begin
      unique case (req.addr)
        DCC_OFF_CONTROL: state_d.rdata = ctl_view;
        DCC_OFF_FLAG:    state_d.rdata = {7'h00, state_q.flag};
        DCC_OFF_ENABLE:  state_d.rdata = {4'h0, state_q.en};
        DCC_OFF_STATUS:  state_d.rdata = {6'h00, state_q.status};
        DCC_OFF_MASK:    state_d.rdata = {6'h00, state_q.mask};
        default:         state_d.rdata = DCC_RST_BYTE;
      endcase
    end
  end

  // State register. Reset gives mode 000, no inversion, flag clear and the
  // comparators powered down. Sleep has no effect here, so the control
  // register keeps its mode, switch and inversion fields through sleep.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q.alive    <= 1'b0;
      state_q.mode     <= DCC_MODE_RESET;
      state_q.in_switch <= 1'b0;
      state_q.inv      <= DCC_RST_PAIR;
      state_q.flag     <= 1'b0;
      state_q.en       <= DCC_RST_EN;
      state_q.status   <= DCC_RST_PAIR;
      state_q.mask     <= DCC_RST_PAIR;
      state_q.captured <= DCC_RST_PAIR;
      state_q.res_s1   <= DCC_RST_PAIR;
      state_q.res_s2   <= DCC_RST_PAIR;
      state_q.pin_s1   <= DCC_RST_BYTE;
      state_q.pin_s2   <= DCC_RST_BYTE;
      state_q.rdata    <= DCC_RST_BYTE;
    end else begin
      state_q <= state_d;
    end
  end

  // Analog controls. Power follows the mode field and is held off through
  // reset; sleep deliberately plays no part so an active comparator keeps
  // running while the core sleeps.
  always_comb begin
    ana.power          = state_q.alive & (state_q.mode != DCC_MODE_OFF);
    ana.mode           = state_q.mode;
    ana.vref_to_plus   = state_q.mode == DCC_MODE_VREF;
    ana.minus_pair_sel = (state_q.mode == DCC_MODE_VREF) & state_q.in_switch;
  end

  assign comp_power_o     = ana.power;
  assign comp_mode_o      = ana.mode;
  assign vref_to_plus_o   = ana.vref_to_plus;
  assign minus_pair_sel_o = ana.minus_pair_sel;

  // Routed pins take the raw comparator level through the inversion only.
  // This path is asynchronous by design: the pin may glitch while the
  // comparator settles, which is the price of zero latency.
  assign result_pin_o    = comp_raw_i ^ state_q.inv;
  assign result_pin_oe_o = {2{state_q.en[DCC_EN_ROUTE]}} & ~port_direction_bits_i;

  // Port reads mask analog pins to zero so a floating analog level never
  // reaches the data path.
  assign port_read_data_o = state_q.pin_s2 & ~dcc_analog_pins(state_q.mode);

  // Interrupt chain: the flag alone never interrupts unless all three enables
  // agree, but wake only needs the comparator's own enable while the core sleeps.
  always_comb begin
    irq_chain = state_q.flag & state_q.en[DCC_EN_CHANGE] & state_q.en[DCC_EN_PERIPH]
              & state_q.en[DCC_EN_GLOBAL];
  end

  assign change_irq_o = irq_chain;
  assign wake_o       = sleep_i & state_q.flag & state_q.en[DCC_EN_CHANGE];
  assign irq_o        = |(state_q.status & state_q.mask);
  assign reg_rdata_o  = state_q.rdata;

endmodule

`default_nettype wire

// [bench/dcc_checker.sv]
// Concurrent checks on the ports of the comparator control block.
`timescale 1ns/1ps
`default_nettype none

module dcc_checker
  import dcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic [1:0] comp_raw_i,
  input  wire logic       comp_power_o,
  input  wire logic [2:0] comp_mode_o,
  input  wire logic       vref_to_plus_o,
  input  wire logic       minus_pair_sel_o,
  input  wire logic [1:0] port_direction_bits_i,
  input  wire logic [1:0] result_pin_o,
  input  wire logic [1:0] result_pin_oe_o,
  input  wire logic [7:0] port_read_data_o,
  input  wire logic       sleep_i,
  input  wire logic       wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Inversion bits as they travel on the write data of a control write.
  wire logic [1:0] inv_w = reg_wdata_i[5:4];

  // A control write is the only step outside reset that may change pin polarity.
  sequence ctl_write;
    reg_we_i && reg_addr_i == DCC_OFF_CONTROL;
  endsequence

  vref_route_a: assert property (vref_to_plus_o == (comp_mode_o == DCC_MODE_VREF))
    else $error("reference routing does not follow the mode");
  pair_sel_a: assert property (minus_pair_sel_o |-> comp_mode_o == DCC_MODE_VREF)
    else $error("pair select outside the reference mode");
  pin_direct_a: assert property (!$past(reg_we_i) |-> $stable(result_pin_o ^ comp_raw_i))
    else $error("result pin does not track the raw output");
  pin_invert_a: assert property (ctl_write |=> result_pin_o == (comp_raw_i ^ $past(inv_w)))
    else $error("result pin polarity wrong after control write");
  driver_gate_a: assert property ((result_pin_oe_o & port_direction_bits_i) == 2'h0)
    else $error("pin driver on while direction is input");
  analog_zero_a: assert property (comp_mode_o == DCC_MODE_RESET |->
    (port_read_data_o & DCC_PINS_ALL_ANALOG) == 8'h00)
    else $error("analog pin reads nonzero");
  power_off_a: assert property ($past(reset_n_i) |->
    comp_power_o == (comp_mode_o != DCC_MODE_OFF))
    else $error("comparator power does not follow the mode");
  reset_mode_a: assert property (!$past(reset_n_i) |->
    comp_mode_o == DCC_MODE_RESET && !comp_power_o)
    else $error("block not in reset mode after reset");
  wake_sleep_a: assert property (wake_o |-> sleep_i)
    else $error("wake raised while not sleeping");
endmodule

`default_nettype wire

// [bench/dcc_comp_model.sv]
// Behavioural pair of analog comparators feeding the control block.
`timescale 1ns/1ps
`default_nettype none

module dcc_comp_model #(
  parameter int RESP_NS = 0
) (
  input  wire logic       power_i,
  input  wire logic [1:0] plus_above_i,
  output logic      [1:0] raw_o
);
  // High when plus exceeds minus; an unpowered part holds its output low.
  // A slow part is modelled by raising the response delay.
  assign #(RESP_NS) raw_o = power_i ? plus_above_i : 2'h0;
endmodule

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module tb;
  import dcc_pkg::*;
  logic       clk_i     = 1'b0;
  logic       reset_n_i = 1'b0;
  dcc_req_t   req       = '0;
  logic [1:0] above     = 2'h0;
  logic [1:0] dir       = 2'h0;
  logic       sleep     = 1'b0;
  logic [7:0] pins      = 8'hFF;
  logic [1:0] raw, pin, oe;
  logic [7:0] rdata, port_rd;
  logic [2:0] mode;
  logic       power, vref, msel, wake, chg_irq, irq;
  int         errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  dcc_comp_model comp_u (.power_i(power), .plus_above_i(above), .raw_o(raw));

  dcc_top dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(req.addr),
    .reg_wdata_i(req.wdata), .reg_we_i(req.we), .reg_re_i(req.re),
    .reg_rdata_o(rdata), .comp_raw_i(raw), .comp_power_o(power),
    .comp_mode_o(mode), .vref_to_plus_o(vref), .minus_pair_sel_o(msel),
    .port_direction_bits_i(dir), .result_pin_o(pin), .result_pin_oe_o(oe),
    .port_pin_level_i(pins), .port_read_data_o(port_rd), .sleep_i(sleep),
    .wake_o(wake), .change_irq_o(chg_irq), .irq_o(irq)
  );

  // Free-running clock; the cycle ceiling cuts a hang short.
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      conclude();
    end
  end

  // Bus tasks; the trailing delay lets the edge's register updates land.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    req.we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    req.re <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  // Reset state and the all-analog port view.
  task automatic t_reset;
    rd(DCC_OFF_CONTROL, 8'h00);
    `CHK(port_rd, 8'h81)
  endtask

  // Result bits ignore writes; off, reference and switch modes.
  task automatic t_modes;
    wr(DCC_OFF_CONTROL, 8'hCF);
    rd(DCC_OFF_CONTROL, 8'h0F);
    `CHK({power, port_rd}, 9'h0FF)
    wr(DCC_OFF_CONTROL, 8'h0E);
    `CHK({vref, msel}, 2'h3)
    wr(DCC_OFF_CONTROL, 8'h06);
    `CHK({vref, msel, port_rd}, 10'h287)
  endtask

  // Rising then falling change, mismatch hold, enable chain and sleep.
  task automatic t_change;
    wr(DCC_OFF_CONTROL, 8'h05);
    wr(DCC_OFF_ENABLE, 8'h07);
    wr(DCC_OFF_MASK, 8'h01);
    @(posedge clk_i);
    above <= 2'h1;
    repeat (4) @(posedge clk_i);
    #1 `CHK({chg_irq, irq}, 2'h3)
    wr(DCC_OFF_FLAG, 8'h00);
    rd(DCC_OFF_FLAG, 8'h01);
    rd(DCC_OFF_CONTROL, 8'h45);
    wr(DCC_OFF_FLAG, 8'h00);
    wr(DCC_OFF_STATUS, 8'h01);
    `CHK({chg_irq, irq}, 2'h0)
    wr(DCC_OFF_ENABLE, 8'h03);
    @(posedge clk_i);
    above <= 2'h0;
    sleep <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 `CHK({chg_irq, wake}, 2'h1)
    rd(DCC_OFF_FLAG, 8'h01);
    @(posedge clk_i);
    sleep <= 1'b0;
    rd(DCC_OFF_CONTROL, 8'h05);
  endtask

  // A written one sets the flag as a simulated event.
  task automatic t_soft;
    wr(DCC_OFF_FLAG, 8'h00);
    rd(DCC_OFF_FLAG, 8'h00);
    wr(DCC_OFF_STATUS, 8'h03);
    wr(DCC_OFF_FLAG, 8'h01);
    rd(DCC_OFF_STATUS, 8'h02);
    rd(DCC_OFF_FLAG, 8'h01);
  endtask

  // Routed pins: direction gating, inversion, no clock sync.
  task automatic t_route;
    wr(DCC_OFF_ENABLE, 8'h08);
    @(posedge clk_i);
    dir <= 2'h2;
    wr(DCC_OFF_CONTROL, 8'h15);
    `CHK({oe, pin}, 4'h5)
    @(posedge clk_i);
    above <= 2'h2;
    #1 `CHK(pin, 2'h3)
    @(posedge clk_i);
    pins <= 8'hC3;
    repeat (3) @(posedge clk_i);
    #1 `CHK(port_rd, 8'h83)
  endtask

  // A reset in mid-run drops power and returns control to its reset state.
  task automatic t_rerun;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    #1 `CHK({power, mode, oe}, 6'h00)
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(DCC_OFF_CONTROL, 8'h00);
  endtask

  // Verdict and end of run.
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_modes();
    t_change();
    t_soft();
    t_route();
    t_rerun();
    conclude();
  end
endmodule

bind dcc_top dcc_checker chk_u (
  .clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .comp_raw_i,
  .comp_power_o, .comp_mode_o, .vref_to_plus_o, .minus_pair_sel_o,
  .port_direction_bits_i, .result_pin_o, .result_pin_oe_o, .port_read_data_o,
  .sleep_i, .wake_o
);

`default_nettype wire
